//--- rtl/pps_supervisor.sv
// Port power-switch supervisor: inrush, trip, clamp and failed-transistor
// control of one port, with an APB register slave.
// Assumes comparator pins from the analog front end and class strobes
// from a classification engine on the same clock.
//
// Contract
// - Standalone invalid 4-then-0..3 class: restart detection
// - Standalone otherwise powers any detected device
// - Status keeps last class and second-pulse flag
// - Turn-on ramps gate, inrush limit, inrush timer
// - Inrush expiry with overcurrent: off, inrush fault
// - Trip-only overcurrent counts trip timer, no limit
// - Trip timer counts down at one sixteenth
// - Trip timer at 60 ms: off, trip fault
// - Clamp limiter always active
// - Clamp timer only with nonzero multiplier
// - Clamp timer at 1.7 ms times multiplier: off
// - Zero multiplier: trip timer counts clamp events
// - Inrush forces 425 mA clamp, then programmed
// - Port off returns clamp setting to 425 mA
// - 425 mA code is 00 or 80 by resistor
// - Per-port two-stage foldback on low output voltage
// - Abnormal voltage over 180 us: port disabled, fault
// - Port reset clears fault; only this port affected
// - Open transistor gives inrush fault, not failed-transistor
// - Semi-auto high-power on without good detect: fault
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "pps_defs.svh"
module pps_supervisor
  import pps_pkg::*;
#(
  parameter int TRIP_US   = `PPS_TRIP_MS * 1000,
  parameter int INRUSH_US = `PPS_INRUSH_MS * 1000
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        over_inrush_i,
  input  wire logic        over_trip_i,
  input  wire logic        at_clamp_i,
  input  wire logic        out_low1_i,
  input  wire logic        out_low2_i,
  input  wire logic        fet_abnormal_i,
  input  wire logic        detect_good_i,
  input  wire logic        class_done_i,
  input  wire logic        class_second_i,
  input  wire logic [2:0]  class_code_i,
  output logic             gate_en_o,
  output logic             inrush_limit_o,
  output logic             gate_weak_pd_o,
  output logic [7:0]       clamp_code_o,
  output logic [1:0]       foldback_o,
  output logic             restart_detect_o
);
  localparam int          TICK_DIV   = `PPS_TICK_NS / `PPS_CLK_NS;
  localparam logic [19:0] TRIP_LIM   = 20'(TRIP_US * 16);
  localparam logic [19:0] INRUSH_LIM = 20'(INRUSH_US);
  localparam logic [7:0]  FET_LIM    = 8'(`PPS_FETBAD_US);

  function automatic pps_code_t forced_code(input logic qtr);
    forced_code = qtr ? `PPS_FORCE_QTR : `PPS_FORCE_HALF;
  endfunction

  function automatic logic [14:0] clamp_lim(input logic [3:0] m);
    clamp_lim = 15'(`PPS_CLAMP_US) * {11'h000, m};
  endfunction

  pps_state_e  state;
  pps_state_e  next_state;
  logic        tick;
  logic [5:0]  pins;
  logic [4:0]  ctrl;
  pps_code_t   clamp_prog;
  logic [3:0]  mult;
  logic [2:0]  class_last;
  logic        hp_ran;
  logic        f_inr;
  logic        f_trip;
  logic        f_clmp;
  logic        f_bad;
  logic [19:0] trip_cnt;
  logic [14:0] clamp_cnt;
  logic [19:0] inrush_cnt;
  logic [7:0]  fet_cnt;
  logic        set_inr;
  logic        set_trip;
  logic        set_clmp;
  logic        set_bad;
  logic        restart;

  // Over-current and voltage comparators are asynchronous to this clock
  pps_sync #(.W(6)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({fet_abnormal_i, out_low2_i, out_low1_i,
                 at_clamp_i, over_trip_i, over_inrush_i}),
    .q_o       (pins)
  );

  pps_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .tick_o    (tick)
  );

  wire ov_inr  = pins[0];
  wire ov_trip = pins[1];
  wire at_clmp = pins[2];
  wire v_low1  = pins[3];
  wire v_low2  = pins[4];
  wire fet_abn = pins[5];

  wire stalone = ctrl[`PPS_C_STALONE - 3];
  wire semi    = ctrl[`PPS_C_SEMI - 3];
  wire hpwr    = ctrl[`PPS_C_HPWR - 3];
  wire qtr     = ctrl[`PPS_C_QTR - 3];
  wire fold_en = ctrl[`PPS_C_FOLD - 3];

  // APB decode; one wait state, write acts at the edge with pready high
  wire acc     = psel_i & penable_i;
  wire done    = acc & pready_o;
  wire wr      = done & pwrite_i;
  wire a_ctrl  = (paddr_i == `PPS_A_CTRL);
  wire a_clamp = (paddr_i == `PPS_A_CLAMP);
  wire a_stat  = (paddr_i == `PPS_A_STAT);
  wire a_trip  = (paddr_i == `PPS_A_TRIP);
  wire mapped  = a_ctrl | a_clamp | a_stat | a_trip;
  wire wr_ctrl = wr & a_ctrl;
  wire cmd_on  = wr_ctrl & pwdata_i[`PPS_C_ON];
  wire cmd_off = wr_ctrl & pwdata_i[`PPS_C_OFF];
  wire prst    = wr_ctrl & pwdata_i[`PPS_C_PRST];
  wire clr_inr = wr & a_stat & pwdata_i[`PPS_S_F_INR];
  wire clr_trp = wr & a_stat & pwdata_i[`PPS_S_F_TRIP];
  wire clr_clm = wr & a_stat & pwdata_i[`PPS_S_F_CLMP];

  wire st_on   = (state == PPS_ON);
  wire st_inr  = (state == PPS_INRUSH);
  wire [31:0] rd_data =
    a_ctrl  ? {24'h000000, ctrl, 3'b000} :
    a_clamp ? {20'h00000, mult, clamp_prog} :
    a_stat  ? {21'h000000, class_last, detect_good_i, hp_ran, f_bad,
               f_clmp, f_trip, f_inr, st_inr, st_on} :
    a_trip  ? {12'h000, trip_cnt} : 32'h00000000;

  // Standalone class outcome
  wire cls4     = (class_code_i == `PPS_CLASS4);
  wire cls_bad  = class_done_i & class_second_i & ~cls4;
  wire cls_wait = class_done_i & ~class_second_i & cls4 & hpwr;
  wire auto_on  = stalone & class_done_i & ~cls_bad & ~cls_wait;
  wire go_on    = cmd_on | auto_on;
  wire refuse   = semi & hpwr & ~detect_good_i;

  // zero multiplier routes clamp events to trip timer
  wire clamp_tmr = (mult != 4'h0);
  wire trip_over = ov_trip | (at_clmp & ~clamp_tmr);
  wire trip_exp  = (trip_cnt >= TRIP_LIM);
  wire clamp_exp = clamp_tmr & (clamp_cnt >= clamp_lim(mult));
  wire inr_exp   = (inrush_cnt >= INRUSH_LIM);
  wire fet_exp   = (fet_cnt > FET_LIM);
  wire powered   = (next_state == PPS_ON) | (next_state == PPS_INRUSH);

  always_comb begin
    next_state = state;
    set_inr    = 1'b0;
    set_trip   = 1'b0;
    set_clmp   = 1'b0;
    set_bad    = 1'b0;
    restart    = 1'b0;
    if (prst) begin
      // port reset recovers a bad port
      next_state = PPS_OFF;
    end else if (fet_exp && state != PPS_BAD) begin
      next_state = PPS_BAD;
      set_bad    = 1'b1;
    end else begin
      case (state)
        PPS_OFF: begin
          if (stalone && cls_bad) begin
            restart = 1'b1;
          end
          // semi-auto high power needs good detect
          if (cmd_on && refuse) begin
            set_inr = 1'b1;
          end else if (go_on) begin
            next_state = PPS_INRUSH;
          end
        end
        PPS_INRUSH: begin
          if (cmd_off) begin
            next_state = PPS_OFF;
          end else if (inr_exp) begin
            // still over inrush level at expiry
            // open transistor leaves output low, same fault
            if (ov_inr || v_low1) begin
              next_state = PPS_OFF;
              set_inr    = 1'b1;
            end else begin
              next_state = PPS_ON;
            end
          end
        end
        PPS_ON: begin
          if (cmd_off) begin
            next_state = PPS_OFF;
          end else if (trip_exp) begin
            next_state = PPS_OFF;
            set_trip   = 1'b1;
          end else if (clamp_exp) begin
            next_state = PPS_OFF;
            set_clmp   = 1'b1;
          end
        end
        PPS_BAD: begin
          next_state = PPS_BAD;
        end
        default: begin
          next_state = PPS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state <= PPS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // inrush timer runs for the whole inrush period
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || next_state != PPS_INRUSH) begin
      inrush_cnt <= 20'h00000;
    end else if (tick && !inr_exp) begin
      inrush_cnt <= inrush_cnt + 20'h00001;
    end
  end

  // trip-only overcurrent counts up by the fast step
  // below threshold counts down one per tick
  // cleared when off, floor at zero
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !powered) begin
      trip_cnt <= 20'h00000;
    end else if (tick && st_on) begin
      if (trip_over) begin
        trip_cnt <= trip_cnt + `PPS_TRIP_STEP;
      end else if (trip_cnt != 20'h00000) begin
        trip_cnt <= trip_cnt - 20'h00001;
      end
    end
  end

  // clamp timer only with nonzero multiplier, while at clamp
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !powered || !clamp_tmr || !at_clmp) begin
      clamp_cnt <= 15'h0000;
    end else if (tick && st_on && !clamp_exp) begin
      clamp_cnt <= clamp_cnt + 15'h0001;
    end
  end

  // Failed-transistor watch runs in every state but the bad one
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || !fet_abn || prst || state == PPS_BAD) begin
      fet_cnt <= 8'h00;
    end else if (tick && !fet_exp) begin
      fet_cnt <= fet_cnt + 8'h01;
    end
  end

  // Registers; hardware set wins over a software clear
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ctrl       <= `PPS_CTRL_RST;
      mult       <= `PPS_MULT_RST;
      clamp_prog <= `PPS_FORCE_HALF;
      class_last <= 3'h0;
      hp_ran     <= 1'b0;
      f_inr      <= 1'b0;
      f_trip     <= 1'b0;
      f_clmp     <= 1'b0;
      f_bad      <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata_i[7:3];
      end
      if (wr && a_clamp) begin
        mult <= pwdata_i[11:8];
      end
      // turning off restores the 425 mA code
      if (!powered && state != PPS_OFF) begin
        clamp_prog <= forced_code(qtr);
      end else if (wr && a_clamp) begin
        clamp_prog <= pwdata_i[7:0];
      end
      if (class_done_i) begin
        class_last <= class_code_i;
        hp_ran     <= class_second_i;
      end
      f_inr  <= set_inr | (f_inr & ~clr_inr & ~prst);
      f_trip <= set_trip | (f_trip & ~clr_trp & ~prst);
      f_clmp <= set_clmp | (f_clmp & ~clr_clm & ~prst);
      f_bad  <= set_bad | (f_bad & ~prst);
    end
  end

  // Outputs, all registered; all but foldback and restart from the next state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gate_en_o        <= 1'b0;
      inrush_limit_o   <= 1'b0;
      gate_weak_pd_o   <= 1'b0;
      clamp_code_o     <= `PPS_FORCE_HALF;
      foldback_o       <= 2'b00;
      restart_detect_o <= 1'b0;
    end else begin
      gate_en_o        <= powered;
      inrush_limit_o   <= (next_state == PPS_INRUSH);
      gate_weak_pd_o   <= (next_state == PPS_BAD);
      clamp_code_o     <= (next_state == PPS_ON) ? clamp_prog : forced_code(qtr);
      // two foldback stages from output voltage
      foldback_o       <= fold_en ? {v_low2, v_low1 & ~v_low2} : 2'b00;
      restart_detect_o <= restart;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      prdata_o  <= (acc & ~pready_o & ~pwrite_i) ? rd_data : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_restart_invalid: assert property (
    (state == PPS_OFF && stalone && cls_bad && !prst && !fet_exp)
      |=> restart_detect_o && state != PPS_INRUSH)
    else $error("invalid class pair did not restart");
  a_inrush_gate: assert property (
    (state == PPS_OFF && cmd_on && !refuse && !prst && !fet_exp)
      |=> st_inr ##1 gate_en_o && inrush_limit_o)
    else $error("turn-on did not start inrush");
  a_inrush_fault: assert property (
    (st_inr && inr_exp && ov_inr && !cmd_off && !prst && !fet_exp)
      |=> state == PPS_OFF && f_inr)
    else $error("inrush expiry missed fault");
  a_trip_down: assert property (
    (st_on && tick && !trip_over && trip_cnt != 20'h00000 && powered)
      |=> trip_cnt == $past(trip_cnt) - 20'h00001)
    else $error("trip timer down step wrong");
  a_trip_expire: assert property (
    (st_on && trip_exp && !cmd_off && !prst && !fet_exp) |=> !st_on && f_trip ##1 !gate_en_o)
    else $error("trip expiry did not turn off");
  a_clamp_idle: assert property (
    !clamp_tmr |=> clamp_cnt == 15'h0000)
    else $error("clamp timer ran with zero multiplier");
  a_forced_code: assert property (
    (st_inr && $stable(qtr)) |-> clamp_code_o == forced_code(qtr))
    else $error("inrush clamp code not forced");
  a_off_restore: assert property (
    (st_on ##1 state == PPS_OFF) |-> clamp_prog == forced_code($past(qtr)))
    else $error("clamp setting not restored at off");
  a_failed_transistor_fault: assert property (
    (fet_exp && state != PPS_BAD && !prst) |=> state == PPS_BAD && f_bad ##1 gate_weak_pd_o)
    else $error("failed transistor not latched");
  a_semi_refuse: assert property (
    (state == PPS_OFF && cmd_on && refuse && !prst && !fet_exp) |=> f_inr && state == PPS_OFF)
    else $error("refused turn-on without fault");
  a_timers_clear: assert property (
    (state == PPS_OFF) |-> trip_cnt == 20'h00000 && clamp_cnt == 15'h0000)
    else $error("timers not cleared while off");
endmodule

//--- rtl/pps_defs.svh
// Constants of the port power supervisor: offsets, fields, resets, times.
// Assumes a 10 MHz system clock and byte addresses on the APB side.
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_CLK_NS      100
`define PPS_TICK_NS     1000
`define PPS_TRIP_MS     60
`define PPS_TRIP_STEP   20'd16
`define PPS_INRUSH_MS   60
`define PPS_CLAMP_US    1700
`define PPS_FETBAD_US   180
`define PPS_A_CTRL      8'h00
`define PPS_A_CLAMP     8'h04
`define PPS_A_STAT      8'h08
`define PPS_A_TRIP      8'h0c
`define PPS_C_ON        0
`define PPS_C_OFF       1
`define PPS_C_PRST      2
`define PPS_C_STALONE   3
`define PPS_C_SEMI      4
`define PPS_C_HPWR      5
`define PPS_C_QTR       6
`define PPS_C_FOLD      7
`define PPS_S_F_INR     2
`define PPS_S_F_TRIP    3
`define PPS_S_F_CLMP    4
`define PPS_CTRL_RST    5'h00
`define PPS_MULT_RST    4'h0
`define PPS_FORCE_HALF  8'h00
`define PPS_FORCE_QTR   8'h80
`define PPS_CLASS4      3'h4
`endif

//--- rtl/pps_pkg.sv
// Types shared by the port power supervisor.
// Constants live in pps_defs.svh.
package pps_pkg;
  typedef enum logic [3:0] {
    PPS_OFF    = 4'b0001,
    PPS_INRUSH = 4'b0010,
    PPS_ON     = 4'b0100,
    PPS_BAD    = 4'b1000
  } pps_state_e;
  typedef logic [7:0] pps_code_t;
endpackage

//--- rtl/pps_sync.sv
// Three-flop synchroniser for comparator pins.
// Output changes only once the second and third flops agree.
`timescale 1ns/1ns
module pps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire  [W-1:0] next_q = (s2 == s3) ? s3 : q_o;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      q_o <= '0;
    end else begin
      s1  <= d_i;
      s2  <= s1;
      s3  <= s2;
      q_o <= next_q;
    end
  end
endmodule

//--- rtl/pps_tick.sv
// Divider giving a one-cycle enable pulse every DIV system clocks.
// All supervisor timers step on this single reference.
`timescale 1ns/1ns
module pps_tick #(
  parameter int DIV = 10
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  output logic      tick_o
);
  logic [7:0] cnt;
  wire        wrap = (cnt == 8'(DIV - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt    <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt    <= wrap ? 8'h00 : cnt + 8'h01;
      tick_o <= wrap;
    end
  end
endmodule

//--- verification/pps_load.sv
// Far-side model: pass transistor, sense resistor and powered device.
// Assumes gate_en_i comes from the supervisor and the levels go to its comparators.
`timescale 1ns/1ns
module pps_load (
  input  wire logic       clk_sys_i,
  input  wire logic       gate_en_i,
  input  wire logic [2:0] mode_i,
  output logic            over_inrush_o,
  output logic            over_trip_o,
  output logic            at_clamp_o,
  output logic            out_low1_o,
  output logic            out_low2_o,
  output logic            fet_abnormal_o
);
  // Modes: 0 normal, 1 overload, 2 hard short, 3 open transistor, 4 shorted transistor
  logic [8:0] chg = 9'h000;
  logic       charging;
  always_ff @(posedge clk_sys_i) begin
    if (!gate_en_i) begin
      chg <= 9'h000;
    end else if (chg != 9'h1ff) begin
      chg <= chg + 9'h001;
    end
  end
  // Output cap takes about 20 us to charge, well inside the inrush period
  assign charging       = gate_en_i && (chg < 9'd200);
  assign over_inrush_o  = charging;
  assign over_trip_o    = charging || (gate_en_i && mode_i == 3'd1);
  assign at_clamp_o     = gate_en_i && mode_i == 3'd2;
  // An open transistor never lifts the output
  assign out_low1_o     = !gate_en_i || charging || mode_i == 3'd2 || mode_i == 3'd3;
  assign out_low2_o     = !gate_en_i || mode_i == 3'd2;
  assign fet_abnormal_o = mode_i == 3'd4;
endmodule

//--- verification/tb_pps_supervisor.sv
// Bench of the port power supervisor: APB master, load model, queued read checks.
// Assumes a one-wait-state APB slave and a 1 us timer tick.
`timescale 1ns/1ns
`include "pps_defs.svh"
module tb_pps_supervisor;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rs = 32'd12578;
  logic        pready_o, pslverr_o, gate_en_o, inrush_limit_o, gate_weak_pd_o;
  logic        restart_detect_o, detect_good_i = 1'b0;
  logic        class_done_i = 1'b0, class_second_i = 1'b0;
  logic [2:0]  class_code_i = 3'h0, mode = 3'd0;
  logic [7:0]  clamp_code_o;
  logic [1:0]  foldback_o;
  wire         oi, ot, ac, l1, l2, fa;
  logic [32:0] q[$];
  int          fail_count = 0, samples_checked = 0;

  pps_supervisor #(.TRIP_US(100), .INRUSH_US(50)) dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .over_inrush_i(oi), .over_trip_i(ot),
    .at_clamp_i(ac), .out_low1_i(l1), .out_low2_i(l2), .fet_abnormal_i(fa),
    .detect_good_i(detect_good_i), .class_done_i(class_done_i),
    .class_second_i(class_second_i), .class_code_i(class_code_i), .gate_en_o(gate_en_o),
    .inrush_limit_o(inrush_limit_o), .gate_weak_pd_o(gate_weak_pd_o),
    .clamp_code_o(clamp_code_o), .foldback_o(foldback_o), .restart_detect_o(restart_detect_o));
  pps_load ld (.clk_sys_i(clk_sys_i), .gate_en_i(gate_en_o), .mode_i(mode),
    .over_inrush_o(oi), .over_trip_o(ot), .at_clamp_o(ac), .out_low1_o(l1),
    .out_low2_o(l2), .fet_abnormal_o(fa));

  initial forever #50 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: return gate_en_o;
      1: return gate_weak_pd_o;
      2: return restart_detect_o;
      default: return inrush_limit_o;
    endcase
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      cmp({pslverr_o, prdata_o}, q.pop_front());
    end
  end

  task automatic waitv(input int s, input logic v, input int n);
    for (int i = 0; i < n && pick(s) !== v; i++) @(posedge clk_sys_i);
    cmp(33'(pick(s)), 33'(v));
  endtask

  task automatic clr(input string s);
    mode <= 3'd0;
    apb(1'b1, `PPS_A_STAT, 32'h1c);
    rd(`PPS_A_STAT, {25'h0, detect_good_i, 7'h0});
    $display("test %s done", s);
  endtask

  task automatic pon(input logic [7:0] ctl, input logic [7:0] code, input logic [3:0] mult);
    apb(1'b1, `PPS_A_CLAMP, {rs[31:12], mult, code});
    rs = xs(rs);
    apb(1'b1, `PPS_A_CTRL, {24'h0, ctl | 8'h01});
    waitv(0, 1'b1, 10);
    // Resistor bit written with the on command applies a cycle later
    cyc(1);
    cmp(33'(clamp_code_o), ctl[6] ? 33'h80 : 33'h00);
    cyc(450);
    cmp(33'(inrush_limit_o), 33'h1);
    cmp(33'(foldback_o), (ctl[7] && mode == 3'd3) ? 33'h1 : 33'h0);
    waitv(3, 1'b0, 150);
    cyc(2);
    cmp(33'(clamp_code_o), 33'(code));
  endtask

  task automatic cls(input logic [2:0] c, input logic sec);
    @(posedge clk_sys_i);
    class_done_i <= 1'b1;
    class_code_i <= c;
    class_second_i <= sec;
    @(posedge clk_sys_i);
    class_done_i <= 1'b0;
  endtask

  initial begin
    cyc(6);
    rst_b_i <= 1'b1;
    rd(`PPS_A_CTRL, 33'h0);
    rd(`PPS_A_CLAMP, 33'h0);
    rd(`PPS_A_STAT, 33'h0);
    rd(`PPS_A_TRIP, 33'h0);
    rd(8'h10, 33'h100000000);
    $display("test regs done");
    pon(8'h00, 8'h40, 4'h0);
    rd(`PPS_A_STAT, 33'h001);
    rd(`PPS_A_CLAMP, 33'h040);
    apb(1'b1, `PPS_A_CTRL, 32'h02);
    waitv(0, 1'b0, 10);
    cyc(2);
    cmp(33'(clamp_code_o), 33'h00);
    rd(`PPS_A_CLAMP, 33'h0);
    clr("on_off");
    pon(8'h00, 8'h40, 4'h0);
    mode <= 3'd1;
    cyc(500);
    cmp(33'(inrush_limit_o), 33'h0);
    mode <= 3'd0;
    cyc(1000);
    mode <= 3'd1;
    cyc(520);
    cmp(33'(gate_en_o), 33'h1);
    waitv(0, 1'b0, 150);
    rd(`PPS_A_STAT, 33'h008);
    rd(`PPS_A_TRIP, 33'h0);
    clr("trip");
    pon(8'h80, 8'h40, 4'h0);
    mode <= 3'd2;
    cyc(20);
    cmp(33'(foldback_o), 33'h2);
    cyc(880);
    cmp(33'(gate_en_o), 33'h1);
    waitv(0, 1'b0, 200);
    rd(`PPS_A_STAT, 33'h008);
    clr("clamp_zero");
    pon(8'h00, 8'h40, 4'h1);
    mode <= 3'd2;
    cyc(16500);
    cmp(33'(gate_en_o), 33'h1);
    waitv(0, 1'b0, 1000);
    rd(`PPS_A_STAT, 33'h010);
    clr("clamp_timer");
    mode <= 3'd3;
    pon(8'hc0, 8'h80, 4'h0);
    waitv(0, 1'b0, 20);
    rd(`PPS_A_STAT, 33'h004);
    cmp(33'(gate_weak_pd_o), 33'h0);
    clr("open_fet");
    pon(8'h00, 8'h40, 4'h0);
    mode <= 3'd4;
    cyc(1750);
    cmp(33'(gate_weak_pd_o), 33'h0);
    waitv(1, 1'b1, 200);
    cmp(33'(gate_en_o), 33'h0);
    rd(`PPS_A_STAT, 33'h020);
    mode <= 3'd0;
    apb(1'b1, `PPS_A_CTRL, 32'h04);
    waitv(1, 1'b0, 10);
    clr("bad_fet");
    // Mode bits must stand before the on command is judged
    apb(1'b1, `PPS_A_CTRL, 32'h30);
    apb(1'b1, `PPS_A_CTRL, 32'h31);
    cyc(20);
    cmp(33'(gate_en_o), 33'h0);
    rd(`PPS_A_STAT, 33'h004);
    detect_good_i <= 1'b1;
    clr("semi_refuse");
    pon(8'h30, 8'h40, 4'h0);
    rd(`PPS_A_STAT, 33'h081);
    apb(1'b1, `PPS_A_CTRL, 32'h02);
    clr("semi_good");
    apb(1'b1, `PPS_A_CTRL, 32'h28);
    cls(3'h4, 1'b0);
    cls(3'h2, 1'b1);
    waitv(2, 1'b1, 8);
    cmp(33'(gate_en_o), 33'h0);
    rd(`PPS_A_STAT, 33'h2c0);
    cls({1'b0, rs[1:0]}, 1'b0);
    waitv(0, 1'b1, 10);
    apb(1'b1, `PPS_A_CTRL, 32'h02);
    $display("test class done");
    close_out();
  end

  initial begin
    cyc(60000);
    fail_count++;
    close_out();
  end
endmodule
